// ### design/e1_irq_map.svh
// register map, field positions, reset values of the receive alarm irq block
// assumes a 32-bit ahb-lite window, registers one word each
`ifndef E1_IRQ_MAP_SVH
`define E1_IRQ_MAP_SVH

`define OFS_IRQ_ENABLE   8'h00
`define OFS_IRQ_STATUS   8'h04
`define OFS_IRQ_MASK     8'h08
`define OFS_FRAMING_CTRL 8'h0c
`define OFS_ALARM_STATE  8'h10

`define BIT_YEL_CHANGE   0
`define BIT_AIS_CHANGE   1
`define BIT_MFA_CHANGE   7
`define BIT_CAS_ENABLE   0
`define BIT_THR_LO       5
`define BIT_THR_HI       6
`define BIT_ST_YEL       0
`define BIT_ST_AIS       1
`define BIT_ST_MFA_LOSS  2

`define STATUS_USED      8'h83
`define RST_IRQ_ENABLE   2'h0
`define RST_IRQ_MASK     1'h0
`define RST_THRESHOLD    2'h0
`define RST_CAS_ENABLE   1'h0
`define RST_STATUS       8'h00

`endif

// ### design/e1_irq_pkg.sv
// types shared by the receive alarm irq block
// assumes nothing beyond the map header
package e1_irq_pkg;
	typedef logic [31:0] word_t;
	typedef logic [7:0]  byte_t;
	typedef logic [1:0]  thr_t;
	typedef logic [2:0]  mfa_cnt_t;
	typedef enum logic [2:0]
	{
		SEL_NONE   = 3'b000,
		SEL_ENABLE = 3'b001,
		SEL_STATUS = 3'b010,
		SEL_MASK   = 3'b011,
		SEL_FCR    = 3'b100,
		SEL_STATE  = 3'b101
	} reg_sel_t;
endpackage : e1_irq_pkg

// ### design/mfa_if.sv
// link between the irq core and the multiframe alignment loss monitor
// assumes both ends share sys_clk
`timescale 1ns/10ps
interface mfa_if;
	logic                 mfa_stb;
	logic                 mfa_err;
	e1_irq_pkg::thr_t     threshold;
	logic                 loss;
	modport mon  (input mfa_stb, input mfa_err, input threshold, output loss);
	modport core (output mfa_stb, output mfa_err, output threshold,
		input loss);
endinterface : mfa_if

// ### design/cas_mfa_loss.sv
// counts consecutive errored cas multiframe alignment signals
// assumes one strobe per received alignment signal, synchronous inputs
`timescale 1ns/10ps
`include "e1_irq_map.svh"
module cas_mfa_loss
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// monitor side of the link
	mfa_if.mon              m
);
	import e1_irq_pkg::*;

	mfa_cnt_t cnt_q;
	mfa_cnt_t cnt_d;
	logic     loss_q;
	logic     loss_d;
	mfa_cnt_t limit;

	// threshold field n means n+1 consecutive errors
	assign limit = mfa_cnt_t'(m.threshold) + 3'h1;

	always_comb
	begin
		cnt_d  = cnt_q;
		loss_d = loss_q;
		if (m.mfa_stb)
		begin
			if (m.mfa_err)
			begin
				if (cnt_q < limit)
					cnt_d = cnt_q + 3'h1;
				if (cnt_q + 3'h1 >= limit)
					loss_d = 1'b1; // R5
			end
			else
			begin
				cnt_d  = 3'h0;
				loss_d = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q  <= 3'h0;
			loss_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			loss_q <= loss_d;
		end
	end

	assign m.loss = loss_q;

	sequence s_err_at_limit;
		m.mfa_stb && m.mfa_err && (cnt_q + 3'h1 >= limit);
	endsequence

	property p_loss_declare;
		@(posedge sys_clk) disable iff (rst)
		s_err_at_limit |=> loss_q;
	endproperty
	a_loss_declare: assert property (p_loss_declare) // R5
		else $error("loss not declared at threshold");

	property p_loss_not_early;
		@(posedge sys_clk) disable iff (rst)
		(!loss_q && !(m.mfa_stb && m.mfa_err && (cnt_q + 3'h1 >= limit)))
			|=> !loss_q;
	endproperty
	a_loss_not_early: assert property (p_loss_not_early) // R5
		else $error("loss declared before threshold");
endmodule : cas_mfa_loss

// ### design/e1_rx_alarm_irq_logic.sv
// interrupt enable and status logic of the receive e1 framer, one channel
// assumes an ahb-lite master, synchronous framer event inputs
//
// How it works
// R1: ais change interrupts gated by enable bit 1
// R2: yellow change interrupts gated by enable bit 0
// R3: alignment loss change sets status bit 7
// R4: status bit reads set, clears on read
// R5: loss after threshold consecutive errored alignment signals
// R6: threshold from framing control bits 6 to 5
// R7: alignment changes reported only with cas enabled
// R8: yellow by two equal a bits, non-fas
// R9: irq high while enabled status bit set
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "e1_irq_map.svh"
module e1_rx_alarm_irq_logic
(
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire e1_irq_pkg::word_t  haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire e1_irq_pkg::word_t  hwdata,
	input  wire logic               hready,
	output e1_irq_pkg::word_t       hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// framer receive events
	input  wire logic               ais_state,
	input  wire logic               nfas_stb,
	input  wire logic               nfas_a_bit,
	input  wire logic               mfa_stb,
	input  wire logic               mfa_err,
	// interrupt
	output logic                    irq
);
	import e1_irq_pkg::*;

	function automatic reg_sel_t decode_addr(input byte_t a);
		unique case (a)
			`OFS_IRQ_ENABLE:   decode_addr = SEL_ENABLE;
			`OFS_IRQ_STATUS:   decode_addr = SEL_STATUS;
			`OFS_IRQ_MASK:     decode_addr = SEL_MASK;
			`OFS_FRAMING_CTRL: decode_addr = SEL_FCR;
			`OFS_ALARM_STATE:  decode_addr = SEL_STATE;
			default:           decode_addr = SEL_NONE;
		endcase
	endfunction : decode_addr

	// bus state
	logic     wr_pend_q;
	logic     wr_pend_d;
	reg_sel_t wr_sel_q;
	reg_sel_t wr_sel_d;
	word_t    rdata_q;
	word_t    rdata_d;
	// software registers
	logic [1:0] en_q;
	logic [1:0] en_d;
	logic       mask_q;
	logic       mask_d;
	thr_t       thr_q;
	thr_t       thr_d;
	logic       cas_en_q;
	logic       cas_en_d;
	byte_t      status_q;
	byte_t      status_d;
	// alarm tracking
	logic       ais_q;
	logic       ais_d;
	logic       yel_q;
	logic       yel_d;
	logic       prev_a_q;
	logic       prev_a_d;
	logic       a_seen_q;
	logic       a_seen_d;
	logic       loss_prev_q;
	logic       loss_prev_d;
	// combinational helpers
	logic       addr_ok;
	reg_sel_t   addr_sel;
	byte_t      set_vec;
	byte_t      clr_vec;
	byte_t      irq_en;
	logic       cas_chg;

	mfa_if mfa ();

	assign mfa.mfa_stb   = mfa_stb;
	assign mfa.mfa_err   = mfa_err;
	assign mfa.threshold = thr_q; // R6

	cas_mfa_loss u_mfa_loss // R5
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.m       (mfa.mon)
	);

	assign addr_ok  = hsel && hready && htrans[1];
	assign addr_sel = decode_addr(haddr[7:0]);

	// yellow alarm on two consecutive equal a bits
	always_comb
	begin
		yel_d    = yel_q;
		prev_a_d = prev_a_q;
		a_seen_d = a_seen_q;
		if (nfas_stb)
		begin
			prev_a_d = nfas_a_bit;
			a_seen_d = 1'b1;
			if (a_seen_q && (prev_a_q == nfas_a_bit))
				yel_d = nfas_a_bit; // R8
		end
	end

	// change events, status and interrupt
	always_comb
	begin
		ais_d       = ais_state;
		loss_prev_d = mfa.loss;
		cas_chg     = (mfa.loss != loss_prev_q) && cas_en_q; // R7
		set_vec     = 8'h00;
		set_vec[`BIT_AIS_CHANGE] = ais_state != ais_q; // R1
		set_vec[`BIT_YEL_CHANGE] = yel_d != yel_q; // R2
		set_vec[`BIT_MFA_CHANGE] = cas_chg; // R3
		clr_vec = 8'h00;
		if (addr_ok && !hwrite && (addr_sel == SEL_STATUS))
			clr_vec = status_q; // R4
		if (wr_pend_q && (wr_sel_q == SEL_STATUS))
			clr_vec = clr_vec | hwdata[7:0];
		// a new event wins over a clear in the same cycle
		status_d = ((status_q & ~clr_vec) | set_vec) & `STATUS_USED;
		irq_en   = 8'h00;
		irq_en[`BIT_MFA_CHANGE] = mask_q;
		irq_en[`BIT_AIS_CHANGE] = en_q[1]; // R1
		irq_en[`BIT_YEL_CHANGE] = en_q[0]; // R2
	end

	assign irq = |(status_q & irq_en); // R9

	// bus: read data captured in the address phase, writes in data phase
	always_comb
	begin
		wr_pend_d = addr_ok && hwrite;
		wr_sel_d  = addr_ok ? addr_sel : SEL_NONE;
		rdata_d   = rdata_q;
		en_d      = en_q;
		mask_d    = mask_q;
		thr_d     = thr_q;
		cas_en_d  = cas_en_q;
		if (addr_ok && !hwrite)
		begin
			rdata_d = 32'h0000_0000;
			unique case (addr_sel)
				SEL_ENABLE: rdata_d[1:0] = en_q;
				SEL_STATUS: rdata_d[7:0] = status_q; // R4
				SEL_MASK:   rdata_d[`BIT_MFA_CHANGE] = mask_q;
				SEL_FCR:
				begin
					rdata_d[`BIT_THR_HI:`BIT_THR_LO] = thr_q;
					rdata_d[`BIT_CAS_ENABLE] = cas_en_q;
				end
				SEL_STATE:
				begin
					rdata_d[`BIT_ST_YEL]      = yel_q;
					rdata_d[`BIT_ST_AIS]      = ais_q;
					rdata_d[`BIT_ST_MFA_LOSS] = mfa.loss;
				end
				SEL_NONE:   rdata_d = 32'h0000_0000;
			endcase
		end
		if (wr_pend_q)
		begin
			unique case (wr_sel_q)
				SEL_ENABLE: en_d   = hwdata[1:0];
				SEL_MASK:   mask_d = hwdata[`BIT_MFA_CHANGE];
				SEL_FCR:
				begin
					thr_d    = hwdata[`BIT_THR_HI:`BIT_THR_LO]; // R6
					cas_en_d = hwdata[`BIT_CAS_ENABLE];
				end
				SEL_STATUS, SEL_STATE, SEL_NONE: ;
			endcase
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_pend_q   <= 1'b0;
			wr_sel_q    <= SEL_NONE;
			rdata_q     <= 32'h0000_0000;
			en_q        <= `RST_IRQ_ENABLE;
			mask_q      <= `RST_IRQ_MASK;
			thr_q       <= `RST_THRESHOLD;
			cas_en_q    <= `RST_CAS_ENABLE;
			status_q    <= `RST_STATUS;
			ais_q       <= 1'b0;
			yel_q       <= 1'b0;
			prev_a_q    <= 1'b0;
			a_seen_q    <= 1'b0;
			loss_prev_q <= 1'b0;
		end
		else
		begin
			wr_pend_q   <= wr_pend_d;
			wr_sel_q    <= wr_sel_d;
			rdata_q     <= rdata_d;
			en_q        <= en_d;
			mask_q      <= mask_d;
			thr_q       <= thr_d;
			cas_en_q    <= cas_en_d;
			status_q    <= status_d;
			ais_q       <= ais_d;
			yel_q       <= yel_d;
			prev_a_q    <= prev_a_d;
			a_seen_q    <= a_seen_d;
			loss_prev_q <= loss_prev_d;
		end
	end

	sequence s_status_read;
		addr_ok && !hwrite && (addr_sel == SEL_STATUS) && status_q[7]
			&& !cas_chg;
	endsequence

	sequence s_fcr_write;
		addr_ok && hwrite && (addr_sel == SEL_FCR) ##1 1'b1;
	endsequence

	property p_ais_event;
		@(posedge sys_clk) disable iff (rst)
		(ais_state != ais_q) |=> status_q[`BIT_AIS_CHANGE];
	endproperty
	a_ais_event: assert property (p_ais_event) // R1
		else $error("ais change did not set status");

	property p_ais_gate;
		@(posedge sys_clk) disable iff (rst)
		(status_q == 8'h02 && !en_q[1]) |-> !irq;
	endproperty
	a_ais_gate: assert property (p_ais_gate) // R1
		else $error("ais interrupt raised while disabled");

	property p_yel_event;
		@(posedge sys_clk) disable iff (rst)
		(nfas_stb && a_seen_q && prev_a_q == nfas_a_bit
			&& nfas_a_bit != yel_q) |=> status_q[`BIT_YEL_CHANGE]
			&& (yel_q == $past(nfas_a_bit));
	endproperty
	a_yel_event: assert property (p_yel_event) // R8
		else $error("yellow alarm change missed");

	property p_yel_gate;
		@(posedge sys_clk) disable iff (rst)
		(status_q[`BIT_YEL_CHANGE] && en_q[0]) |-> irq;
	endproperty
	a_yel_gate: assert property (p_yel_gate) // R2
		else $error("enabled yellow change gives no irq");

	property p_mfa_event;
		@(posedge sys_clk) disable iff (rst)
		(mfa.loss != loss_prev_q && cas_en_q)
			|=> status_q[`BIT_MFA_CHANGE];
	endproperty
	a_mfa_event: assert property (p_mfa_event) // R3
		else $error("alignment change did not set status");

	property p_read_clears;
		@(posedge sys_clk) disable iff (rst)
		s_status_read |=> hrdata[7] && !status_q[7];
	endproperty
	a_read_clears: assert property (p_read_clears) // R4
		else $error("status read did not return and clear");

	property p_threshold;
		@(posedge sys_clk) disable iff (rst)
		s_fcr_write |=> thr_q == $past(hwdata[6:5]);
	endproperty
	a_threshold: assert property (p_threshold) // R6
		else $error("threshold field not taken");

	property p_cas_off;
		@(posedge sys_clk) disable iff (rst)
		(!cas_en_q && !status_q[7]) |=> !status_q[7];
	endproperty
	a_cas_off: assert property (p_cas_off) // R7
		else $error("alignment change reported with cas off");

	property p_irq_cause;
		@(posedge sys_clk) disable iff (rst)
		irq |-> (status_q[7] && mask_q) || (status_q[1] && en_q[1])
			|| (status_q[0] && en_q[0]);
	endproperty
	a_irq_cause: assert property (p_irq_cause) // R9
		else $error("irq without enabled status");
endmodule : e1_rx_alarm_irq_logic

// ### dv/e1_rx_alarm_irq_logic_test.sv
// self-checking bench of the receive alarm irq block
// assumes the map header offsets and a zero-wait ahb-lite slave
`timescale 1ns/10ps
`include "e1_irq_map.svh"
module e1_rx_alarm_irq_logic_test;
	import e1_irq_pkg::*;

	logic   sys_clk;
	logic   rst;
	logic   hsel;
	word_t  haddr;
	logic   [1:0] htrans;
	logic   hwrite;
	logic   [2:0] hsize;
	word_t  hwdata;
	wire    hready;
	word_t  hrdata;
	logic   hreadyout;
	logic   hresp;
	logic   ais_state;
	logic   nfas_stb;
	logic   nfas_a_bit;
	logic   mfa_stb;
	logic   mfa_err;
	logic   irq;
	int     n_mismatch;
	int     total_checks;

	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	e1_rx_alarm_irq_logic e1_rx_alarm_irq_logic_i
	(
		.sys_clk    (sys_clk),
		.rst        (rst),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (hsize),
		.hwdata     (hwdata),
		.hready     (hready),
		.hrdata     (hrdata),
		.hreadyout  (hreadyout),
		.hresp      (hresp),
		.ais_state  (ais_state),
		.nfas_stb   (nfas_stb),
		.nfas_a_bit (nfas_a_bit),
		.mfa_stb    (mfa_stb),
		.mfa_err    (mfa_err),
		.irq        (irq)
	);

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input word_t exp, input word_t got);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic chk_irq(input logic exp);
		chk("irq", {31'h0, exp}, {31'h0, irq});
	endtask : chk_irq

	// one single transfer, called just after a rising edge
	task automatic xfer(input byte_t a, input logic w, input word_t wd,
		output word_t rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge sys_clk);
		while (hready !== 1'b1)
			@(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hready !== 1'b1)
			@(posedge sys_clk);
		rd = hrdata;
		// slave must answer every transfer with an OKAY response
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : xfer

	task automatic wr(input byte_t a, input word_t d);
		word_t unused;
		xfer(a, 1'b1, d, unused);
	endtask : wr

	task automatic rchk(input byte_t a, input word_t exp, input string nm);
		word_t d;
		xfer(a, 1'b0, 32'h0, d);
		chk(nm, exp, d);
	endtask : rchk

	task automatic nfas(input logic a);
		nfas_stb <= 1'b1;
		nfas_a_bit <= a;
		@(posedge sys_clk);
		nfas_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : nfas

	task automatic mfa(input logic e);
		mfa_stb <= 1'b1;
		mfa_err <= e;
		@(posedge sys_clk);
		mfa_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : mfa

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		ais_state = 1'b0;
		nfas_stb = 1'b0;
		nfas_a_bit = 1'b0;
		mfa_stb = 1'b0;
		mfa_err = 1'b0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rchk(`OFS_IRQ_ENABLE, 32'h0, "enable");
		rchk(`OFS_IRQ_STATUS, 32'h0, "status");
		rchk(`OFS_IRQ_MASK, 32'h0, "mask");
		rchk(`OFS_FRAMING_CTRL, 32'h0, "fcr");
		rchk(`OFS_ALARM_STATE, 32'h0, "state");
		wr(8'h14, 32'hffffffff);
		rchk(8'h14, 32'h0, "unmapped");
		wr(`OFS_IRQ_ENABLE, 32'hffffffff);
		rchk(`OFS_IRQ_ENABLE, 32'h3, "enable");
		chk_irq(1'b0);
		$display("test reset_and_map done");
		// ais declare and clear, with only yellow then only ais enabled
		for (int i = 0; i < 4; i++)
		begin
			wr(`OFS_IRQ_ENABLE, (i < 2) ? 32'h1 : 32'h2);
			ais_state <= ~ais_state;
			repeat (3) @(posedge sys_clk);
			chk_irq(i >= 2);
			rchk(`OFS_ALARM_STATE, (i % 2 == 0) ? 32'h2 : 32'h0, "state");
			rchk(`OFS_IRQ_STATUS, 32'h2, "status");
			chk_irq(1'b0);
		end
		$display("test ais_change done");
		wr(`OFS_IRQ_ENABLE, 32'h1);
		nfas(1'b1);
		repeat (2) @(posedge sys_clk);
		rchk(`OFS_ALARM_STATE, 32'h0, "state");
		chk_irq(1'b0);
		nfas(1'b1);
		repeat (2) @(posedge sys_clk);
		rchk(`OFS_ALARM_STATE, 32'h1, "state");
		chk_irq(1'b1);
		rchk(`OFS_IRQ_STATUS, 32'h1, "status");
		nfas(1'b0);
		nfas(1'b1);
		repeat (2) @(posedge sys_clk);
		rchk(`OFS_IRQ_STATUS, 32'h0, "status");
		nfas(1'b0);
		nfas(1'b0);
		repeat (2) @(posedge sys_clk);
		chk_irq(1'b1);
		rchk(`OFS_ALARM_STATE, 32'h0, "state");
		rchk(`OFS_IRQ_STATUS, 32'h1, "status");
		$display("test yellow_change done");
		wr(`OFS_IRQ_MASK, 32'h80);
		rchk(`OFS_IRQ_MASK, 32'h80, "mask");
		for (int n = 0; n < 4; n++)
		begin
			wr(`OFS_FRAMING_CTRL, (n << 5) | 1);
			rchk(`OFS_FRAMING_CTRL, (n << 5) | 1, "fcr");
			repeat (n) mfa(1'b1);
			mfa(1'b0);
			repeat (n) mfa(1'b1);
			repeat (2) @(posedge sys_clk);
			rchk(`OFS_ALARM_STATE, 32'h0, "state");
			chk_irq(1'b0);
			mfa(1'b1);
			repeat (2) @(posedge sys_clk);
			rchk(`OFS_ALARM_STATE, 32'h4, "state");
			chk_irq(1'b1);
			wr(`OFS_IRQ_STATUS, 32'h80);
			// the clear lands on the edge that ends the write
			@(posedge sys_clk);
			chk_irq(1'b0);
			rchk(`OFS_IRQ_STATUS, 32'h0, "status");
			mfa(1'b0);
			repeat (2) @(posedge sys_clk);
			chk_irq(1'b1);
			rchk(`OFS_IRQ_STATUS, 32'h80, "status");
			rchk(`OFS_IRQ_STATUS, 32'h0, "status");
		end
		$display("test mfa_loss done");
		wr(`OFS_FRAMING_CTRL, 32'h0);
		mfa(1'b1);
		repeat (2) @(posedge sys_clk);
		rchk(`OFS_IRQ_STATUS, 32'h0, "status");
		chk_irq(1'b0);
		mfa(1'b0);
		$display("test cas_disabled done");
		stop_test();
	end
endmodule : e1_rx_alarm_irq_logic_test
